// ---- rtl/link_regs_pkg.sv ----
package link_regs_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TOPO_STATUS = 8'h68;
    localparam logic [7:0] OFS_CHMASK_UP_SET = 8'h70;
    localparam logic [7:0] OFS_CHMASK_UP_CLR = 8'h74;
    localparam logic [7:0] OFS_CHMASK_LO_SET = 8'h78;
    localparam logic [7:0] OFS_CHMASK_LO_CLR = 8'h7c;
    localparam logic [7:0] OFS_EVENT_SET = 8'h80;
    localparam logic [7:0] OFS_EVENT_CLR = 8'h84;
    localparam logic [7:0] OFS_ENABLE_SET = 8'h88;
    localparam logic [7:0] OFS_ENABLE_CLR = 8'h8c;
    // Secondary registers: tx event, tx enable, rx event, rx enable
    localparam logic [7:0] OFS_SEC_BASE = 8'h90;
    localparam logic [7:0] OFS_SEC_STRIDE = 8'h08;

    // ------------------------------------------------------------
    // Topology status field layout
    // ------------------------------------------------------------
    localparam int TOPO_ERR_BIT = 31;
    localparam int TOPO_GEN_LSB = 16;
    localparam int TOPO_GEN_W = 8;
    localparam int TOPO_CNT_LSB = 2;
    localparam int TOPO_CNT_W = 11;

    // ------------------------------------------------------------
    // Event register layout
    // ------------------------------------------------------------
    localparam logic [31:0] EVENT_IMPL_MASK = 32'h07ff_ffff;
    localparam logic [31:0] EVENT_RO_MASK = 32'h0000_00c0;
    localparam int EVENT_ISO_TX_BIT = 6;
    localparam int EVENT_ISO_RX_BIT = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [TOPO_GEN_W-1:0] GEN_RESET = 8'h00;
    localparam logic [TOPO_CNT_W-1:0] CNT_RESET = 11'h000;

    // Index of a secondary register set or clear address, or 4 when none
    function automatic logic [2:0] sec_index(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - OFS_SEC_BASE;
        if (addr >= OFS_SEC_BASE && rel < 8'(4 * OFS_SEC_STRIDE)) begin
            sec_index = 3'(rel >> 3);
        end else begin
            sec_index = 3'd4;
        end
    endfunction

endpackage

// ---- rtl/set_clear_reg.sv ----
`timescale 1ns/10ps
// Register with separate set and clear write strobes plus hardware set
module set_clear_reg #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] RO_MASK = '0,
    parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic set_wr_i,
    input wire logic clr_wr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [WIDTH-1:0] hw_set_i,
    output logic [WIDTH-1:0] value_o
);
    logic [WIDTH-1:0] value_r; // Stored bits
    logic [WIDTH-1:0] value_nxt; // Next stored bits

    // ------------------------------------------------------------
    // Next value
    // ------------------------------------------------------------
    // Clear first, then sets, so a hardware event in the clearing
    // cycle survives instead of being lost
    always_comb begin
        value_nxt = value_r;
        if (clr_wr_i) begin
            value_nxt = value_nxt & ~wdata_i;
        end
        if (set_wr_i) begin
            value_nxt = value_nxt | (wdata_i & ~RO_MASK);
        end
        value_nxt = (value_nxt | hw_set_i) & IMPL_MASK;
    end

    // Register stage
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            value_r <= '0;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign value_o = value_r;
endmodule // set_clear_reg

// ---- rtl/selfid_chanmask_irq_regs.sv ----
`timescale 1ns/10ps
module selfid_chanmask_irq_regs
    import link_regs_pkg::*;
#(
    parameter int DMA_EVENTS = 6 // Low event bits fed by DMA engines
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Register access port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Topology packet reception
    input wire logic bus_reset_i,
    input wire logic quadlet_stored_i,
    input wire logic reception_done_i,
    input wire logic reception_hw_error_i,
    input wire logic reception_write_fail_i,
    // Interrupt sources
    input wire logic [DMA_EVENTS-1:0] dma_done_i,
    input wire logic [31:0] device_line_i,
    input wire logic [31:0] iso_tx_ctx_event_i,
    input wire logic [31:0] iso_rx_ctx_event_i,
    // Results
    output logic [63:0] rx_channel_enable_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic topo_err_r; // Latest reception failed
    logic topo_err_nxt;
    logic [TOPO_GEN_W-1:0] gen_r; // Bus reset generation
    logic [TOPO_GEN_W-1:0] gen_nxt;
    logic [TOPO_CNT_W-1:0] qcount_r; // Quadlets in topology buffer
    logic [TOPO_CNT_W-1:0] qcount_nxt;
    logic [31:0] mask_upper_r; // Channels 63..32
    logic [31:0] mask_upper_nxt;
    logic [31:0] mask_lower_r; // Channels 31..0
    logic [31:0] mask_lower_nxt;
    logic [31:0] line_prev_r; // Device lines one cycle ago
    logic [31:0] line_prev_nxt;
    logic [31:0] rdata_r; // Read data holding register
    logic [31:0] rdata_nxt;
    logic rvalid_r; // Read answer strobe
    logic rvalid_nxt;

    logic wr_event_set; // Write strobes per address
    logic wr_event_clr;
    logic wr_enable_set;
    logic wr_enable_clr;
    logic [2:0] sec_idx; // Secondary register index, 4 if none
    logic sec_is_clr; // Secondary access hits clear address
    logic [3:0] sec_set_wr;
    logic [3:0] sec_clr_wr;
    logic [31:0] sec_hw_set [4]; // Hardware set inputs per register
    logic [31:0] sec_value [4]; // Secondary register contents
    logic [31:0] event_hw_set; // Hardware sets into event bits
    logic [31:0] event_bits; // irq_event_bits
    logic [31:0] enable_bits; // irq_enable_bits
    logic [31:0] topo_status; // Assembled status word

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Plain equality against the event and enable offsets, a range check for the secondary block; accesses are whole words
    always_comb begin
        wr_event_set = reg_wr_i && (reg_addr_i == OFS_EVENT_SET);
        wr_event_clr = reg_wr_i && (reg_addr_i == OFS_EVENT_CLR);
        wr_enable_set = reg_wr_i && (reg_addr_i == OFS_ENABLE_SET);
        wr_enable_clr = reg_wr_i && (reg_addr_i == OFS_ENABLE_CLR);
        sec_idx = sec_index(reg_addr_i);
        sec_is_clr = reg_addr_i[2];
        sec_set_wr = '0;
        sec_clr_wr = '0;
        if (reg_wr_i && sec_idx != 3'd4) begin
            if (sec_is_clr) begin
                sec_clr_wr[sec_idx[1:0]] = 1'b1;
            end else begin
                sec_set_wr[sec_idx[1:0]] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Topology status
    // ------------------------------------------------------------
    // Bus reset takes priority over a quadlet store in the same cycle:
    // that quadlet belongs to the generation now being discarded
    always_comb begin
        topo_err_nxt = topo_err_r;
        gen_nxt = gen_r;
        qcount_nxt = qcount_r;
        if (reception_done_i) begin
            // Either error source marks the buffer untrustworthy
            topo_err_nxt = reception_hw_error_i | reception_write_fail_i;
        end
        if (bus_reset_i) begin
            gen_nxt = gen_r + 8'h01;
            qcount_nxt = CNT_RESET;
        end else if (quadlet_stored_i && qcount_r != '1) begin
            // Header and data quadlets both count; saturate, never wrap
            qcount_nxt = qcount_r + 11'h001;
        end
    end

    // Register stage
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            topo_err_r <= 1'b0;
            gen_r <= GEN_RESET;
            qcount_r <= CNT_RESET;
        end else begin
            topo_err_r <= topo_err_nxt;
            gen_r <= gen_nxt;
            qcount_r <= qcount_nxt;
        end
    end

    // Reserved fields read as zero
    always_comb begin
        topo_status = '0;
        topo_status[TOPO_ERR_BIT] = topo_err_r;
        topo_status[TOPO_GEN_LSB +: TOPO_GEN_W] = gen_r;
        topo_status[TOPO_CNT_LSB +: TOPO_CNT_W] = qcount_r;
    end

    // ------------------------------------------------------------
    // Channel receive mask
    // ------------------------------------------------------------
    // Set and clear use separate addresses, so the two never hit in one cycle
    always_comb begin
        mask_upper_nxt = mask_upper_r;
        mask_lower_nxt = mask_lower_r;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                OFS_CHMASK_UP_SET: begin
                    mask_upper_nxt = mask_upper_r | reg_wdata_i;
                end
                OFS_CHMASK_UP_CLR: begin
                    mask_upper_nxt = mask_upper_r & ~reg_wdata_i;
                end
                OFS_CHMASK_LO_SET: begin
                    mask_lower_nxt = mask_lower_r | reg_wdata_i;
                end
                OFS_CHMASK_LO_CLR: begin
                    mask_lower_nxt = mask_lower_r & ~reg_wdata_i;
                end
                default: begin
                    // Other addresses leave the mask alone
                end
            endcase
        end
    end

    // Bus reset is deliberately not an input here; only the chip
    // reset clears the mask, to a known all-disabled state
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            mask_upper_r <= REG_RESET;
            mask_lower_r <= REG_RESET;
        end else begin
            mask_upper_r <= mask_upper_nxt;
            mask_lower_r <= mask_lower_nxt;
        end
    end

    // Upper word drives channels 63..32, lower word 31..0
    assign rx_channel_enable_o = {mask_upper_r, mask_lower_r};

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    // Lines come from logic on this clock, so no synchroniser
    always_comb begin
        line_prev_nxt = device_line_i;
    end

    // Previous line state for rising edge detection
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            line_prev_r <= REG_RESET;
        end else begin
            line_prev_r <= line_prev_nxt;
        end
    end

    // Low bits take DMA completions, the rest device line edges;
    // the two context bits follow the secondary registers as levels
    always_comb begin
        event_hw_set = device_line_i & ~line_prev_r;
        event_hw_set[DMA_EVENTS-1:0] = dma_done_i;
        event_hw_set[EVENT_ISO_TX_BIT] = |(sec_value[0] & sec_value[1]);
        event_hw_set[EVENT_ISO_RX_BIT] = |(sec_value[2] & sec_value[3]);
    end

    // ------------------------------------------------------------
    // Interrupt event and enable registers
    // ------------------------------------------------------------
    set_clear_reg #(
        .WIDTH(32),
        .RO_MASK(EVENT_RO_MASK),
        .IMPL_MASK(EVENT_IMPL_MASK)
    ) u_event (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .set_wr_i(wr_event_set),
        .clr_wr_i(wr_event_clr),
        .wdata_i(reg_wdata_i),
        .hw_set_i(event_hw_set),
        .value_o(event_bits)
    );

    set_clear_reg #(
        .WIDTH(32),
        .RO_MASK(32'h0000_0000),
        .IMPL_MASK(32'hffff_ffff)
    ) u_enable (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .set_wr_i(wr_enable_set),
        .clr_wr_i(wr_enable_clr),
        .wdata_i(reg_wdata_i),
        .hw_set_i(32'h0000_0000),
        .value_o(enable_bits)
    );

    // ------------------------------------------------------------
    // Secondary context registers
    // ------------------------------------------------------------
    // Even entries are context events set by hardware, odd ones enables
    always_comb begin
        sec_hw_set[0] = iso_tx_ctx_event_i;
        sec_hw_set[1] = '0;
        sec_hw_set[2] = iso_rx_ctx_event_i;
        sec_hw_set[3] = '0;
    end

    for (genvar g = 0; g < 4; g++) begin : g_sec
        set_clear_reg #(
            .WIDTH(32),
            .RO_MASK(32'h0000_0000),
            .IMPL_MASK(32'hffff_ffff)
        ) u_sec (
            .core_clk_i(core_clk_i),
            .resetn_i(resetn_i),
            .set_wr_i(sec_set_wr[g]),
            .clr_wr_i(sec_clr_wr[g]),
            .wdata_i(reg_wdata_i),
            .hw_set_i(sec_hw_set[g]),
            .value_o(sec_value[g])
        );
    end

    // ------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------
    // Combinational from flops: drops the cycle after the clear write
    // lands, and stays up if an enabled event set in that cycle
    assign irq_o = |(event_bits & enable_bits);

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Answer one cycle after the strobe; unmapped addresses read zero
    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = reg_rd_i;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_TOPO_STATUS: rdata_nxt = topo_status;
                OFS_CHMASK_UP_SET, OFS_CHMASK_UP_CLR: begin
                    rdata_nxt = mask_upper_r;
                end
                OFS_CHMASK_LO_SET, OFS_CHMASK_LO_CLR: begin
                    rdata_nxt = mask_lower_r;
                end
                OFS_EVENT_SET: rdata_nxt = event_bits;
                OFS_EVENT_CLR: rdata_nxt = event_bits & enable_bits;
                OFS_ENABLE_SET, OFS_ENABLE_CLR: rdata_nxt = enable_bits;
                default: begin
                    if (sec_idx != 3'd4) begin
                        rdata_nxt = sec_value[sec_idx[1:0]];
                    end else begin
                        rdata_nxt = REG_RESET;
                    end
                end
            endcase
        end
    end

    // Register stage
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            rdata_r <= REG_RESET;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;

endmodule // selfid_chanmask_irq_regs

// ---- verif/selfid_regs_sva.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the register bank
// ----------------------------------------
module selfid_regs_sva
    import link_regs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic [63:0] rx_channel_enable_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Any read of the four channel mask words
    wire logic mask_rd = reg_rd_i && reg_addr_i[7:4] == 4'h7 && reg_addr_i[1:0] == 2'b00;
    AST_RD_ANSWER: assert property (
        reg_rd_i |=> reg_rvalid_o) else $error("read strobe not answered");
    AST_NO_SPURIOUS_VALID: assert property (
        !reg_rd_i |=> !reg_rvalid_o) else $error("valid without read");
    AST_MASK_READ: assert property (
        mask_rd |=> reg_rdata_o == ($past(reg_addr_i[3]) ? $past(rx_channel_enable_o[31:0])
            : $past(rx_channel_enable_o[63:32]))) else $error("mask read mismatch");
    AST_LO_SET: assert property (
        reg_wr_i && reg_addr_i == OFS_CHMASK_LO_SET |=> rx_channel_enable_o[31:0] ==
            ($past(rx_channel_enable_o[31:0]) | $past(reg_wdata_i))) else $error("lower set wrong");
    AST_LO_CLR: assert property (
        reg_wr_i && reg_addr_i == OFS_CHMASK_LO_CLR |=> rx_channel_enable_o[31:0] ==
            ($past(rx_channel_enable_o[31:0]) & ~$past(reg_wdata_i))) else $error("lower clear wrong");
    AST_UP_SET: assert property (
        reg_wr_i && reg_addr_i == OFS_CHMASK_UP_SET |=> rx_channel_enable_o[63:32] ==
            ($past(rx_channel_enable_o[63:32]) | $past(reg_wdata_i))) else $error("upper set wrong");
    AST_UP_CLR: assert property (
        reg_wr_i && reg_addr_i == OFS_CHMASK_UP_CLR |=> rx_channel_enable_o[63:32] ==
            ($past(rx_channel_enable_o[63:32]) & ~$past(reg_wdata_i))) else $error("upper clear wrong");
    // Bus resets and any cycle without a register write must leave the mask alone
    AST_MASK_HOLD: assert property (
        !reg_wr_i |=> $stable(rx_channel_enable_o)) else $error("mask moved without write");
    AST_IRQ_MASKED_OFF: assert property (
        reg_wr_i && reg_addr_i == OFS_ENABLE_CLR && reg_wdata_i == 32'hffff_ffff |=> !irq_o)
        else $error("request with all enables clear");
endmodule // selfid_regs_sva
bind selfid_chanmask_irq_regs selfid_regs_sva u_sva (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .rx_channel_enable_o(rx_channel_enable_o),
    .irq_o(irq_o));

// ---- verif/link_side_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Topology reception source: bus reset, quadlets, done
// ----------------------------------------
module link_side_model (
    input wire logic core_clk_i,
    input wire logic start_i, // Request one reception
    input wire logic [3:0] nquad_i, // Quadlets to store
    input wire logic hw_err_i, // Error levels to report at done
    input wire logic wr_fail_i,
    output logic bus_reset_o,
    output logic quadlet_o,
    output logic done_o,
    output logic hw_err_o,
    output logic wr_fail_o,
    output logic busy_o
);
    // Error lines show the inverse outside the done cycle, since they are only valid with it.
    // Outputs move by non-blocking assignment, so a bench sampling busy on the same
    // falling edge always sees the old value and never races this process
    initial begin
        {bus_reset_o, quadlet_o, done_o, hw_err_o, wr_fail_o, busy_o} = 6'h00;
        forever begin
            @(posedge core_clk_i);
            if (start_i) begin
                @(negedge core_clk_i);
                busy_o <= 1'b1;
                bus_reset_o <= 1'b1;
                hw_err_o <= ~hw_err_i;
                wr_fail_o <= ~wr_fail_i;
                @(negedge core_clk_i);
                bus_reset_o <= 1'b0;
                // One quadlet per cycle held high
                quadlet_o <= (nquad_i != 4'h0);
                repeat (nquad_i) @(negedge core_clk_i);
                quadlet_o <= 1'b0;
                done_o <= 1'b1;
                hw_err_o <= hw_err_i;
                wr_fail_o <= wr_fail_i;
                @(negedge core_clk_i);
                done_o <= 1'b0;
                hw_err_o <= ~hw_err_i;
                wr_fail_o <= ~wr_fail_i;
                busy_o <= 1'b0;
            end
        end
    end
endmodule // link_side_model

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
    $display("CHECK FAILED %s exp=%h got=%h", nm, ex, got); end end
module tb_top;
    import link_regs_pkg::*;
    // ----------------------------------------
    // Stimulus and observation signals
    // ----------------------------------------
    logic core_clk_i = 1'b0;
    logic resetn_i, wr, rd, rvalid, irq, brst, quad, done, hwe, wfl, start, m_hw, m_wf, busy;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, line, rxe, txe, ev, rv;
    logic [5:0] dma;
    logic [3:0] nq;
    logic [63:0] en;
    int error_cnt = 0;
    int cmp_count = 0;
    int i;
    always #4 core_clk_i = ~core_clk_i;
    selfid_chanmask_irq_regs #(.DMA_EVENTS(6)) dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .bus_reset_i(brst), .quadlet_stored_i(quad), .reception_done_i(done),
        .reception_hw_error_i(hwe), .reception_write_fail_i(wfl), .dma_done_i(dma), .device_line_i(line),
        .iso_tx_ctx_event_i(txe), .iso_rx_ctx_event_i(rxe), .rx_channel_enable_o(en), .irq_o(irq));
    link_side_model u_link (.core_clk_i(core_clk_i), .start_i(start), .nquad_i(nq), .hw_err_i(m_hw),
        .wr_fail_i(m_wf), .bus_reset_o(brst), .quadlet_o(quad), .done_o(done), .hw_err_o(hwe),
        .wr_fail_o(wfl), .busy_o(busy));
    // ----------------------------------------
    // Access tasks, all driven at the falling edge
    // ----------------------------------------
    task automatic close_out;
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge core_clk_i);
        wr = 1'b0;
    endtask
    // Answer comes exactly one cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(negedge core_clk_i);
        addr = a;
        rd = 1'b1;
        @(negedge core_clk_i);
        rd = 1'b0;
        `CHK("rvalid", 1'b1, rvalid)
        d = rdata;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rreg(a, rv);
        `CHK(nm, e, rv)
    endtask
    task automatic tchk(input logic e, input logic [7:0] g, input logic [10:0] c);
        rchk("topo", OFS_TOPO_STATUS, {e, 7'h00, g, 3'h0, c, 2'b00});
    endtask
    // One reception from the link side, bounded wait on its busy flag
    task automatic topo(input logic [3:0] n, input logic h, input logic f);
        int k;
        k = 0;
        @(negedge core_clk_i);
        nq = n;
        m_hw = h;
        m_wf = f;
        start = 1'b1;
        while (!busy && k < 20) begin
            @(negedge core_clk_i);
            k++;
        end
        start = 1'b0;
        while (busy && k < 60) begin
            @(negedge core_clk_i);
            k++;
        end
        if (busy || k >= 20) begin
            error_cnt++;
            close_out();
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {wr, rd, start, m_hw, m_wf, addr, wdata, line, rxe, txe, dma, nq} = '0;
        resetn_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        resetn_i = 1'b1;
        tchk(1'b0, 8'h00, 11'h000);
        // Channel mask: set, zero write, clear, per-word readback
        wreg(OFS_CHMASK_LO_SET, 32'ha5a5_0f0f);
        wreg(OFS_CHMASK_UP_SET, 32'h8000_0001);
        wreg(OFS_CHMASK_LO_SET, 32'h0000_0000);
        wreg(OFS_CHMASK_LO_CLR, 32'h0000_000f);
        wreg(OFS_CHMASK_UP_CLR, 32'h8000_0000);
        `CHK("mask", 64'h0000_0001_a5a5_0f00, en)
        for (i = 0; i < 4; i++) rchk("mask_rd", OFS_CHMASK_UP_SET + 8'(4 * i), i < 2 ? 32'h1 : 32'ha5a5_0f00);
        // Receptions: each error source, then clean ones through the generation wrap
        topo(4'd3, 1'b1, 1'b0);
        tchk(1'b1, 8'd1, 11'd3);
        topo(4'd5, 1'b0, 1'b1);
        tchk(1'b1, 8'd2, 11'd5);
        topo(4'd7, 1'b0, 1'b0);
        tchk(1'b0, 8'd3, 11'd7);
        topo(4'd0, 1'b0, 1'b0);
        tchk(1'b0, 8'd4, 11'd0);
        `CHK("mask_kept", 64'h0000_0001_a5a5_0f00, en)
        for (i = 5; i <= 255; i++) topo(4'd0, 1'b0, 1'b0);
        tchk(1'b0, 8'd255, 11'd0);
        topo(4'd0, 1'b0, 1'b0);
        tchk(1'b0, 8'd0, 11'd0);
        // Event and enable registers
        wreg(OFS_ENABLE_SET, 32'hffff_ffff);
        wreg(OFS_EVENT_SET, 32'h0000_01c0);
        `CHK("irq_on", 1'b1, irq)
        rchk("ev_raw", OFS_EVENT_SET, 32'h0000_0100);
        wreg(OFS_ENABLE_CLR, 32'h0000_0100);
        `CHK("irq_masked", 1'b0, irq)
        rchk("ev_masked", OFS_EVENT_CLR, 32'h0);
        rchk("ev_raw", OFS_EVENT_SET, 32'h0000_0100);
        wreg(OFS_EVENT_SET, 32'h0);
        wreg(OFS_EVENT_CLR, 32'h0);
        rchk("ev_zero_wr", OFS_EVENT_SET, 32'h0000_0100);
        wreg(OFS_ENABLE_SET, 32'h0000_0100);
        // DMA completion and a device line edge, line left standing high
        @(negedge core_clk_i) dma[2] = 1'b1;
        @(negedge core_clk_i) dma[2] = 1'b0;
        line[20] = 1'b1;
        repeat (2) @(negedge core_clk_i);
        rreg(OFS_EVENT_SET, ev);
        `CHK("ev_src", 32'h0010_0104, ev)
        wreg(OFS_EVENT_CLR, ev);
        `CHK("irq_drop", 1'b0, irq)
        rchk("ev_clr", OFS_EVENT_SET, 32'h0);
        // Secondary context registers feed event bits 6 and 7
        wreg(OFS_SEC_BASE + 8'h08, 32'h1);
        wreg(OFS_SEC_BASE, 32'h1);
        // Bit 6 follows the context registers one edge after the write
        @(negedge core_clk_i);
        `CHK("irq_tx", 1'b1, irq)
        wreg(OFS_SEC_BASE + 8'h04, 32'h1);
        rchk("sec_tx", OFS_SEC_BASE, 32'h0);
        wreg(OFS_EVENT_CLR, 32'h0000_0040);
        rchk("ev_tx", OFS_EVENT_SET, 32'h0);
        @(negedge core_clk_i) rxe[3] = 1'b1;
        @(negedge core_clk_i) rxe[3] = 1'b0;
        rchk("sec_rx", OFS_SEC_BASE + 8'h10, 32'h8);
        // Hardware set into the transmit event word, its enable bit differs
        @(negedge core_clk_i) txe[1] = 1'b1;
        @(negedge core_clk_i) txe[1] = 1'b0;
        rchk("sec_tx_hw", OFS_SEC_BASE, 32'h2);
        // Receive enable matching the stored receive event raises bit 7
        wreg(OFS_SEC_BASE + 8'h18, 32'h8);
        rchk("ev_rx", OFS_EVENT_SET, 32'h0000_0080);
        `CHK("irq_rx", 1'b1, irq)
        wreg(OFS_ENABLE_CLR, 32'hffff_ffff);
        `CHK("irq_all_off", 1'b0, irq)
        rchk("unmapped", 8'h60, 32'h0);
        // Second reset mid-run
        @(negedge core_clk_i) resetn_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        resetn_i = 1'b1;
        tchk(1'b0, 8'd0, 11'd0);
        close_out();
    end
endmodule // tb_top
